// ---- logic/irq_ctrl_regs.vh ----
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define RG_FLAGS_IDX 4'h0
`define RG_CTRL_IDX 4'h9
`define RG_FLAGS_ADDR {2'b00, `RG_FLAGS_IDX, 2'b00}
`define RG_CTRL_ADDR {2'b00, `RG_CTRL_IDX, 2'b00}
`define RG_EVSTAT_ADDR 8'h40
`define RG_EVMASK_ADDR 8'h44
`define RG_SHADOW_ADDR 8'h48

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define FLG_PWM 2
`define FLG_C 1
`define FLG_Z 0
`define CTL_GIE 1
`define CTL_RUN 0
`define FLAGS_RST 4'h0
`define CTRL_RST 2'h0
`define EV_CYCLE 0
`define EV_ENTRY 1
`define EV_RETURN 2
`define EV_RST 3'h0

// ----------------------------------------
// Entry addresses
// ----------------------------------------
`define VEC_WAKE 16'h0004
`define VEC_IRQ 16'h0008

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 100000000
`define SAMPLE_HZ 32768
`define SAMPLE_CYC (`CLK_HZ / `SAMPLE_HZ)

`endif

// ---- logic/apb_nibble_slave.v ----
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctrl_regs.vh"

module apb_nibble_slave (
   input wire clock,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire [7:0] paddr,
   output reg pready_q,
   output reg pslverr_q,
   output wire accessStart,
   output wire accessDone,
   output wire [4:0] regHit
);
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   function [4:0] decode;
      input [7:0] a;
      begin
         decode = {a == `RG_SHADOW_ADDR, a == `RG_EVMASK_ADDR, a == `RG_EVSTAT_ADDR,
                   a == `RG_CTRL_ADDR, a == `RG_FLAGS_ADDR};
      end
   endfunction

   assign regHit = decode(paddr);
   // One wait state keeps the read mux off the bus path
   assign accessStart = psel & penable & ~pready_q;
   assign accessDone = psel & penable & pready_q;

   always @(posedge clock) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= accessStart;
         pslverr_q <= accessStart & ~|regHit;
      end
   end
endmodule // apb_nibble_slave

`default_nettype wire

// ---- logic/pwm_cycle_timer.v ----
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctrl_regs.vh"

module pwm_cycle_timer #(
   parameter CYCLES = `SAMPLE_CYC
) (
   input wire clock,
   input wire rst,
   input wire run,
   output reg cycleDone_q
);
   // ----------------------------------------
   // Sample period divider
   // ----------------------------------------
   reg [12:0] count_q;

   always @(posedge clock) begin
      if (rst || !run) begin
         count_q <= 13'h0000;
         cycleDone_q <= 1'b0;
      end else if (count_q == CYCLES[12:0] - 13'h0001) begin
         count_q <= 13'h0000;
         cycleDone_q <= 1'b1;
      end else begin
         count_q <= count_q + 13'h0001;
         cycleDone_q <= 1'b0;
      end
   end
endmodule // pwm_cycle_timer

`default_nettype wire

// ---- logic/single_vector_irq_controller.v ----
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctrl_regs.vh"

module single_vector_irq_controller #(
   parameter PC_W = 14,
   parameter CYCLES = `SAMPLE_CYC
) (
   input wire clock,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [PC_W-1:0] nextPc,
   input wire [3:0] pageDataHigh,
   input wire [3:0] memAddrHigh,
   input wire flagWrite,
   input wire carryIn,
   input wire zeroIn,
   input wire retiExec,
   input wire retsExec,
   input wire wakeup,
   input wire halted,
   output reg pcLoad,
   output reg [PC_W-1:0] pcTarget,
   output reg ctxRestore,
   output reg [3:0] restorePageDataHigh,
   output reg [3:0] restoreMemAddrHigh,
   output reg carryFlag,
   output reg zeroFlag,
   output reg pwmRequestFlag,
   output reg globalIrqEnable,
   output reg pwmRunEnable,
   output reg inService,
   output reg irq
);
   // ----------------------------------------
   // Constants cut to 16-bit vector and field widths
   // ----------------------------------------
   // A PC wider than 16 bits needs wider entry vectors
   localparam [15:0] WAKE_VEC = `VEC_WAKE;
   localparam [15:0] IRQ_VEC = `VEC_IRQ;
   localparam [3:0] FLAGS_INIT = `FLAGS_RST;
   localparam [1:0] CTRL_INIT = `CTRL_RST;
   localparam [2:0] EV_INIT = `EV_RST;

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   wire accessStart;
   wire accessDone;
   wire [4:0] regHit;

   apb_nibble_slave bus (
      .clock(clock),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .paddr(paddr),
      .pready_q(pready),
      .pslverr_q(pslverr),
      .accessStart(accessStart),
      .accessDone(accessDone),
      .regHit(regHit)
   );

   // ----------------------------------------
   // Register strobes
   // ----------------------------------------
   // Writes land only on the edge that completes the access
   wire wrDone;
   wire rdDone;
   wire wrFlags;
   wire wrCtrl;
   wire wrMask;
   wire rdEvStat;

   assign wrDone = accessDone & pwrite;
   assign rdDone = accessDone & ~pwrite;
   assign wrFlags = wrDone & regHit[0];
   assign wrCtrl = wrDone & regHit[1];
   assign wrMask = wrDone & regHit[3];
   assign rdEvStat = rdDone & regHit[2];

   // ----------------------------------------
   // Output cycle source
   // ----------------------------------------
   wire cycleDone;

   // Run low holds the divider, so no request while stopped
   pwm_cycle_timer #(
      .CYCLES(CYCLES)
   ) timer (
      .clock(clock),
      .rst(rst),
      .run(pwmRunEnable),
      .cycleDone_q(cycleDone)
   );

   // ----------------------------------------
   // Shadow context
   // ----------------------------------------
   reg [PC_W-1:0] savedPc_q;
   reg [3:0] savedPage_q;
   reg [3:0] savedAddrHigh_q;
   reg savedCarry_q;
   reg savedZero_q;

   // ----------------------------------------
   // Event status and mask
   // ----------------------------------------
   reg [2:0] evStat_q;
   reg [2:0] evMask_q;

   // ----------------------------------------
   // Sequencing decisions
   // ----------------------------------------
   wire doWake;
   wire doReturn;
   wire doAccept;

   // Wake-up owns the cycle; the pending request waits one more clock
   assign doWake = wakeup;
   // A clash with the subroutine return means a bad decode; treat it as neither
   assign doReturn = retiExec & ~retsExec & inService & ~doWake;
   // Request and enable are both registered, so acceptance lands on the next clock
   assign doAccept = globalIrqEnable & pwmRequestFlag & ~inService & ~halted
                     & ~doWake & ~retiExec;

   // ----------------------------------------
   // Program counter redirect
   // ----------------------------------------
   // Wake beats return beats entry; one redirect per clock
   always @(posedge clock) begin
      if (rst) begin
         pcLoad <= 1'b0;
         pcTarget <= {PC_W{1'b0}};
      end else if (doWake) begin
         pcLoad <= 1'b1;
         pcTarget <= WAKE_VEC[PC_W-1:0];
      end else if (doReturn) begin
         pcLoad <= 1'b1;
         pcTarget <= savedPc_q;
      end else if (doAccept) begin
         pcLoad <= 1'b1;
         pcTarget <= IRQ_VEC[PC_W-1:0];
      end else begin
         pcLoad <= 1'b0;
      end
   end

   // ----------------------------------------
   // Context save
   // ----------------------------------------
   // Registered flags are saved, not the core's flag inputs
   always @(posedge clock) begin
      if (rst) begin
         savedPc_q <= {PC_W{1'b0}};
         savedPage_q <= 4'h0;
         savedAddrHigh_q <= 4'h0;
         savedCarry_q <= 1'b0;
         savedZero_q <= 1'b0;
      end else if (doAccept) begin
         savedPc_q <= nextPc;
         savedPage_q <= pageDataHigh;
         savedAddrHigh_q <= memAddrHigh;
         savedCarry_q <= carryFlag;
         savedZero_q <= zeroFlag;
      end
   end

   // ----------------------------------------
   // Context restore
   // ----------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         ctxRestore <= 1'b0;
         restorePageDataHigh <= 4'h0;
         restoreMemAddrHigh <= 4'h0;
      end else begin
         ctxRestore <= doReturn;
         if (doReturn) begin
            restorePageDataHigh <= savedPage_q;
            restoreMemAddrHigh <= savedAddrHigh_q;
         end
      end
   end

   // ----------------------------------------
   // Service level
   // ----------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         inService <= 1'b0;
      end else if (doAccept) begin
         inService <= 1'b1;
      end else if (doReturn) begin
         inService <= 1'b0;
      end
   end

   // ----------------------------------------
   // Status nibble
   // ----------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         carryFlag <= FLAGS_INIT[`FLG_C];
         zeroFlag <= FLAGS_INIT[`FLG_Z];
      end else if (doReturn) begin
         carryFlag <= savedCarry_q;
         zeroFlag <= savedZero_q;
      end else if (flagWrite) begin
         // Core flag updates beat a bus write to the nibble
         carryFlag <= carryIn;
         zeroFlag <= zeroIn;
      end else if (wrFlags) begin
         carryFlag <= pwdata[`FLG_C];
         zeroFlag <= pwdata[`FLG_Z];
      end
   end

   // ----------------------------------------
   // Request flag
   // ----------------------------------------
   // Entry never touches this flag; the routine must drop it before return
   always @(posedge clock) begin
      if (rst) begin
         pwmRequestFlag <= 1'b0;
      end else if (cycleDone) begin
         pwmRequestFlag <= 1'b1;
      end else if (wrFlags && !pwdata[`FLG_PWM]) begin
         pwmRequestFlag <= 1'b0;
      end
   end

   // ----------------------------------------
   // Control nibble
   // ----------------------------------------
   // Entry and return override a bus write in the same clock
   always @(posedge clock) begin
      if (rst) begin
         globalIrqEnable <= CTRL_INIT[`CTL_GIE];
      end else if (doAccept) begin
         globalIrqEnable <= 1'b0;
      end else if (doReturn) begin
         globalIrqEnable <= 1'b1;
      end else if (wrCtrl) begin
         globalIrqEnable <= pwdata[`CTL_GIE];
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         pwmRunEnable <= CTRL_INIT[`CTL_RUN];
      end else if (wrCtrl) begin
         pwmRunEnable <= pwdata[`CTL_RUN];
      end
   end

   // ----------------------------------------
   // Events, mask, interrupt line
   // ----------------------------------------
   wire [2:0] evSet;
   wire [2:0] evSeen;

   assign evSet = {doReturn, doAccept, cycleDone};
   // Drop only the bits a read handed out, so an event set mid-read survives
   assign evSeen = rdEvStat ? prdata[2:0] : 3'h0;

   always @(posedge clock) begin
      if (rst) begin
         evStat_q <= EV_INIT;
      end else begin
         evStat_q <= (evStat_q & ~evSeen) | evSet;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         evMask_q <= EV_INIT;
      end else if (wrMask) begin
         evMask_q <= pwdata[2:0];
      end
   end

   // ----------------------------------------
   // Interrupt line
   // ----------------------------------------
   // Follows status one clock late so the output is a plain flop
   always @(posedge clock) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(evStat_q & evMask_q);
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // Shadow word is read-only; a write to it is dropped
   function [31:0] readMux;
      input [4:0] hit;
      input [3:0] flags;
      input [1:0] ctrl;
      input [2:0] stat;
      input [2:0] mask;
      input [PC_W:0] shadow;
      begin
         readMux = 32'h00000000;
         if (hit[0]) begin
            readMux[3:0] = flags;
         end
         if (hit[1]) begin
            readMux[1:0] = ctrl;
         end
         if (hit[2]) begin
            readMux[2:0] = stat;
         end
         if (hit[3]) begin
            readMux[2:0] = mask;
         end
         if (hit[4]) begin
            readMux[PC_W:0] = shadow;
         end
      end
   endfunction

   // Reserved bits and unmapped reads return zero
   always @(posedge clock) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (accessStart && !pwrite) begin
         prdata <= readMux(regHit,
                           {1'b0, pwmRequestFlag, carryFlag, zeroFlag},
                           {globalIrqEnable, pwmRunEnable},
                           evStat_q, evMask_q, {inService, savedPc_q});
      end
   end
endmodule // single_vector_irq_controller

`default_nettype wire

// ---- sim/core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// --------
// Core
// --------
module core_model #(
   parameter PC_W = 14
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic pcLoad,
   input wire logic [PC_W-1:0] pcTarget,
   input wire logic ctxRestore,
   input wire logic [3:0] restorePageDataHigh,
   output logic [PC_W-1:0] nextPc,
   output logic [3:0] pageDataHigh,
   output logic [3:0] memAddrHigh
);
   // Context keeps moving, so a stale save is caught
   assign memAddrHigh = ~pageDataHigh;
   always_ff @(posedge clock) begin
      if (rst) begin
         nextPc <= '0;
         pageDataHigh <= 4'h0;
      end else begin
         nextPc <= pcLoad ? pcTarget : nextPc + 1'b1;
         pageDataHigh <= ctxRestore ? restorePageDataHigh : pageDataHigh + 4'h1;
      end
   end
endmodule // core_model
`default_nettype wire

// ---- sim/irq_ctrl_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_properties #(
   parameter PC_W = 14,
   parameter CYCLES = 20
) (
   input wire clock,
   input wire rst,
   input wire [PC_W-1:0] nextPc,
   input wire [3:0] pageDataHigh,
   input wire [3:0] memAddrHigh,
   input wire retiExec,
   input wire retsExec,
   input wire wakeup,
   input wire halted,
   input wire pcLoad,
   input wire [PC_W-1:0] pcTarget,
   input wire ctxRestore,
   input wire [3:0] restorePageDataHigh,
   input wire [3:0] restoreMemAddrHigh,
   input wire carryFlag,
   input wire zeroFlag,
   input wire pwmRequestFlag,
   input wire globalIrqEnable,
   input wire pwmRunEnable,
   input wire inService
);
   // --------
   // Helpers
   // --------
   logic acc;
   logic [PC_W+9:0] ctx_q;
   int wait_q;
   assign acc = globalIrqEnable & pwmRequestFlag & ~inService & ~halted & ~wakeup & ~retiExec;
   always_ff @(posedge clock) begin
      if (acc)
         ctx_q <= {nextPc, pageDataHigh, memAddrHigh, carryFlag, zeroFlag};
      // Flag clears restart the wait; the timer phase never slips longer
      wait_q <= (rst || !pwmRunEnable || pwmRequestFlag) ? 0 : wait_q + 1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence acc_s; acc; endsequence
   sequence ret_s; retiExec && !retsExec && inService && !wakeup; endsequence
   a_entry_vector: assert property (acc_s |=> pcLoad && pcTarget == 32'h8)
      else $error("entry vector wrong");
   a_entry_clears: assert property (acc_s |=> !globalIrqEnable && inService && pwmRequestFlag)
      else $error("entry state wrong");
   a_no_accept: assert property (!globalIrqEnable && !wakeup && !retiExec |=> !pcLoad)
      else $error("accepted while disabled");
   a_no_nesting: assert property (inService && !wakeup && !retiExec |=> !pcLoad)
      else $error("nested entry");
   a_ctx_restore: assert property (ret_s |=> ctxRestore && ctx_q == {pcTarget, restorePageDataHigh,
      restoreMemAddrHigh, carryFlag, zeroFlag})
      else $error("context not restored");
   a_ret_enable: assert property (ret_s |=> globalIrqEnable && !inService && pcLoad)
      else $error("return did not enable");
   a_wake_vector: assert property (wakeup |=> pcLoad && pcTarget == 32'h4)
      else $error("wake vector wrong");
   a_cycle_flag: assert property (wait_q <= CYCLES + 2)
      else $error("request flag late");
   a_return_from_sub_instr_ignored: assert property (retsExec |=> !ctxRestore)
      else $error("subroutine return restored context");
   a_halt_blocks: assert property (halted && !wakeup && !retiExec |=> !pcLoad)
      else $error("accepted while halted");
endmodule // irq_ctrl_properties
bind single_vector_irq_controller irq_ctrl_properties #(.PC_W(PC_W), .CYCLES(CYCLES)) props (.clock, .rst,
   .nextPc, .pageDataHigh, .memAddrHigh, .retiExec, .retsExec, .wakeup, .halted, .pcLoad, .pcTarget, .ctxRestore,
   .restorePageDataHigh, .restoreMemAddrHigh, .carryFlag, .zeroFlag, .pwmRequestFlag, .globalIrqEnable,
   .pwmRunEnable, .inService);
`default_nettype wire

// ---- sim/tb_single_vector_irq_controller.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_single_vector_irq_controller;
   localparam int CYC = 20;
   logic clock, rst, psel, penable, pwrite, flagWrite, carryIn, zeroIn, retiExec, retsExec, halted, wakeup, err;
   logic pready, pslverr, pcLoad, ctxRestore, carryFlag, zeroFlag, pwmRequestFlag;
   logic globalIrqEnable, pwmRunEnable, inService, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [13:0] nextPc, pcTarget;
   logic [3:0] pageDataHigh, memAddrHigh, restorePageDataHigh, restoreMemAddrHigh;
   int mismatches, compares, cycles, n;
   single_vector_irq_controller #(.CYCLES(CYC)) dut (.clock, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .nextPc, .pageDataHigh, .memAddrHigh, .flagWrite, .carryIn,
      .zeroIn, .retiExec, .retsExec, .wakeup, .halted, .pcLoad, .pcTarget, .ctxRestore,
      .restorePageDataHigh, .restoreMemAddrHigh, .carryFlag, .zeroFlag, .pwmRequestFlag,
      .globalIrqEnable, .pwmRunEnable, .inService, .irq);
   core_model core (.clock, .rst, .pcLoad, .pcTarget, .ctxRestore, .restorePageDataHigh, .nextPc,
      .pageDataHigh, .memAddrHigh);
   // --------
   // Tasks
   // --------
   task chk(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         mismatches++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task report_and_stop;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Ends one edge after release so a following setup never overwrites it
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task pulse_flags(input logic c, input logic z);
      flagWrite <= 1'b1;
      carryIn <= c;
      zeroIn <= z;
      @(posedge clock);
      flagWrite <= 1'b0;
      @(posedge clock);
   endtask
   task t_reset;
      apb(0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      apb(0, 8'h24, 32'h0);
      chk(rd, 32'h0);
      apb(0, 8'h10, 32'h0);
      chk(err, 32'h1);
   endtask
   task t_entry;
      pulse_flags(1'b1, 1'b0);
      apb(0, 8'h00, 32'h0);
      chk(rd, 32'h2);
      apb(1, 8'h24, 32'hF);
      apb(0, 8'h24, 32'h0);
      chk(rd, 32'h3);
      while (pcLoad !== 1'b1) @(posedge clock);
      chk(pcTarget, 32'h8);
      chk(globalIrqEnable, 32'h0);
      chk(pwmRequestFlag, 32'h1);
      apb(0, 8'h24, 32'h0);
      chk(rd, 32'h1);
      apb(0, 8'h00, 32'h0);
      chk(rd, 32'h6);
   endtask
   task t_irq;
      apb(1, 8'h44, 32'h0);
      chk(irq, 32'h0);
      apb(1, 8'h44, 32'h2);
      @(posedge clock);
      chk(irq, 32'h1);
      apb(0, 8'h40, 32'h0);
      chk(rd & 32'h2, 32'h2);
      @(posedge clock);
      chk(irq, 32'h0);
   endtask
   task t_return;
      apb(1, 8'h24, 32'h0);
      apb(1, 8'h00, 32'h2);
      apb(0, 8'h00, 32'h0);
      chk(rd, 32'h2);
      apb(1, 8'h24, 32'h3);
      n = 0;
      repeat (2 * CYC) begin
         @(posedge clock);
         n += pcLoad;
      end
      chk(n, 32'h0);
      pulse_flags(1'b0, 1'b1);
      retiExec <= 1'b1;
      @(posedge clock);
      retiExec <= 1'b0;
      @(posedge clock);
      chk({pcLoad, ctxRestore, carryFlag, zeroFlag}, 32'hE);
      chk(globalIrqEnable, 32'h1);
      @(posedge clock);
      chk({pcLoad, pcTarget}, 32'h4008);
   endtask
   task t_wake;
      wakeup <= 1'b1;
      @(posedge clock);
      wakeup <= 1'b0;
      @(posedge clock);
      chk({pcLoad, pcTarget}, 32'h4004);
   endtask
   task t_block;
      apb(0, 8'h48, 32'h0);
      chk(rd >> 14, 32'h1);
      retiExec <= 1'b1;
      retsExec <= 1'b1;
      @(posedge clock);
      retiExec <= 1'b0;
      retsExec <= 1'b0;
      halted <= 1'b1;
      @(posedge clock);
      chk({pcLoad, ctxRestore, inService}, 32'h1);
      retiExec <= 1'b1;
      @(posedge clock);
      retiExec <= 1'b0;
      @(posedge clock);
      chk({pcLoad, globalIrqEnable, inService}, 32'h6);
      n = 0;
      repeat (4) begin
         @(posedge clock);
         n += pcLoad;
      end
      chk(n, 32'h0);
      halted <= 1'b0;
      @(posedge clock);
      @(posedge clock);
      chk({pcLoad, pcTarget}, 32'h4008);
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         report_and_stop;
      end
   end
   initial begin
      {psel, penable, pwrite, flagWrite, carryIn, zeroIn, retiExec, retsExec, halted, wakeup} = 10'h000;
      paddr = 8'h00;
      pwdata = 32'h0;
      rst = 1'b1;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_reset;
      t_entry;
      t_irq;
      t_return;
      t_wake;
      t_block;
      report_and_stop;
   end
endmodule // tb_single_vector_irq_controller
`default_nettype wire
